/* src/dla_pkg.sv */
// package: word layout, control codes, operations and carriers for the long accumulator block
package dla_pkg;
   localparam int WORD_W = 32;
   localparam int LINE_WORDS = 32;
   localparam int MC_W = 5;
   localparam int TOP_DIGIT = WORD_W - 1;
   localparam int CODE_W = 5;
   localparam logic [CODE_W-1:0] CODE_DELAY_ON = 5'h03;
   localparam logic [CODE_W-1:0] CODE_SPLIT_OFF = 5'h04;
   localparam logic [CODE_W-1:0] CODE_SPLIT_ON = 5'h05;
   localparam logic [WORD_W-1:0] WORD_ZERO = 32'h00000000;
   localparam logic [WORD_W-1:0] WORD_ONES = 32'hffffffff;
   localparam logic TRIG_RESET = 1'b0;

   typedef enum logic [1:0] {
      OP_NONE,
      OP_ADD,
      OP_SUB
   } acc_op_t;

   // one transfer beat from the sequencer
   typedef struct packed {
      logic store_wr;                 // write to single_store_input
      logic line_wr;                  // write to recirculating_line
      acc_op_t acc_op;                // add or subtract destination
      logic acc_load;                 // plain load of the addressed accumulator word
      logic ctrl_wr;                  // control_trigger_destination strobe
      logic [CODE_W-1:0] ctrl_code;   // control code (source number)
      logic [WORD_W-1:0] data;        // word on the transfer bus
   } xfer_t;

   typedef struct packed {
      logic delay_chain_trigger;
      logic split_word_trigger;
      logic extending;
   } trig_state_t;
endpackage : dla_pkg

/* src/double_length_accumulator.sv */
// double-length accumulator with split-word and delay-chain triggers, one word per cycle
// Function
// RQ1 - delay-chain on: single-word store keeps nothing, loop broken, passes line words
// RQ2 - delay-chain on: store output is line word of previous minor cycle
// RQ3 - 32-word line; store acts as 33rd one-word stage when chained
// RQ4 - any write to store input turns delay-chain off and stores the word
// RQ5 - chained path lets a line word be written one position later
// RQ6 - code 3 sets delay-chain, 4 clears split, 5 sets split; no data moves
// RQ7 - even word is low half, odd word is high half of 64 digits
// RQ8 - double length: only odd top digit is the sign
// RQ9 - split off: carry or borrow passes from even word into odd word
// RQ10 - split on: two independent signed words, no carry between them
// RQ11 - shift source gives addressed word down one place, accumulator unchanged
// RQ12 - split off: shifted even top digit comes from odd lowest digit
// RQ13 - shifted odd word replicates its sign digit
// RQ14 - split on: shifted even word replicates its own top digit
// RQ15 - n-place double shift needs 2n cycles of shift-to-accumulator transfer
// RQ16 - add destination adds, subtract destination subtracts, same parity word
// RQ17 - sequencer orders multi-cycle accumulator transfers even first then odd
// RQ18 - split off: add or subtract ending on even cycle extends one cycle
// RQ19 - extension word is all zeros or all ones from last digit sent
// RQ20 - split on: add and subtract are never extended
// RQ21 - words move least digit first, last digit is the sign
// RQ22 - triggers hold until changed by code, or store write for delay-chain
`timescale 1ns/100ps
module double_length_accumulator
   import dla_pkg::*;
#(
   parameter int WIDTH = dla_pkg::WORD_W,
   parameter int DEPTH = dla_pkg::LINE_WORDS
) (
   input wire logic clk,                             // 100 MHz clock, one minor cycle per edge
   input wire logic arst_n,                          // asynchronous reset, active low
   input wire logic clk_en,                          // freezes all state while low
   input wire logic [dla_pkg::MC_W-1:0] minor_cycle, // current minor cycle number
   input wire dla_pkg::xfer_t xfer,                  // transfer beat from sequencer
   output logic [WIDTH-1:0] line_out,                // recirculating line word of the previous minor cycle
   output logic [WIDTH-1:0] store_out,               // single_store_output word
   output logic [WIDTH-1:0] shift_out,               // shift_down_source word
   output logic [WIDTH-1:0] acc_out,                 // addressed long accumulator word
   output dla_pkg::trig_state_t trig_out,            // trigger and extension state
   output logic busy                                 // extension cycle in progress, sequencer holds off
);
   import dla_pkg::*;

   // line words live in an array of their own; the line is not reset
   logic [WIDTH-1:0] line_mem [DEPTH];
   logic [WIDTH-1:0] store_q;
   logic [WIDTH-1:0] acc_even_q;
   logic [WIDTH-1:0] acc_odd_q;
   logic delay_chain_q;
   logic split_q;
   logic carry_q;
   logic carry_valid_q;
   logic ext_q;
   logic ext_sub_q;
   logic ext_sign_q;

   logic [WIDTH-1:0] line_rd;
   logic [WIDTH-1:0] store_rd;
   logic line_we;
   logic store_we;

   logic odd_cycle;
   logic double_mode;
   logic seq_op;
   logic ext_beat;
   logic arm_ext;
   logic top_digit_in;
   logic code_delay_on;
   logic code_split_off;
   logic code_split_on;

   // adder and shifter work on the half addressed by this minor cycle
   logic [WIDTH-1:0] acc_cur;
   logic [WIDTH-1:0] acc_new;
   logic [WIDTH-1:0] operand;
   logic [WIDTH-1:0] ext_word;
   logic [WIDTH-1:0] shift_d;
   logic [WIDTH:0] sum_w;
   logic carry_in;
   logic carry_out;
   logic acc_active;
   logic op_sub;

   // arithmetic shift down by one, top filled from given digit
   function automatic logic [WIDTH-1:0] shift_one(input logic [WIDTH-1:0] w, input logic fill);
      shift_one = {fill, w[WIDTH-1:1]};
   endfunction : shift_one

   // control strobe carrying one code; no data word moves with it
   function automatic logic is_code(input xfer_t x, input logic [CODE_W-1:0] code);
      is_code = x.ctrl_wr && (x.ctrl_code == code);
   endfunction : is_code

   // all zeros or all ones from one digit
   function automatic logic [WIDTH-1:0] sign_word(input logic digit);
      sign_word = digit ? WORD_ONES : WORD_ZERO;
   endfunction : sign_word

   // subtract folds into the adder as a + ~b + carry in, carry out 1 meaning no borrow
   function automatic logic [WIDTH:0] add_word(input logic [WIDTH-1:0] a, input logic [WIDTH-1:0] b,
      input logic sub, input logic cin);
      logic [WIDTH-1:0] b_eff;
      b_eff = sub ? ~b : b;
      add_word = {1'b0, a} + {1'b0, b_eff} + {{WIDTH{1'b0}}, cin};
   endfunction : add_word

   // one-place downward shift of the addressed half
   function automatic logic [WIDTH-1:0] shift_half(input logic odd, input logic split,
      input logic [WIDTH-1:0] even_w, input logic [WIDTH-1:0] odd_w);
      if (odd) begin
         shift_half = shift_one(odd_w, odd_w[TOP_DIGIT]); // see RQ8 see RQ13
      end else if (split) begin
         shift_half = shift_one(even_w, even_w[TOP_DIGIT]); // see RQ14
      end else begin
         shift_half = shift_one(even_w, odd_w[0]); // see RQ12
      end
   endfunction : shift_half

   assign odd_cycle = minor_cycle[0];
   assign double_mode = !split_q;
   assign line_rd = line_mem[minor_cycle];
   // chained, the store shows the word the line presented one minor cycle ago
   assign store_rd = store_q; // see RQ2
   assign line_we = clk_en && xfer.line_wr;
   assign store_we = clk_en && xfer.store_wr;
   assign top_digit_in = xfer.data[TOP_DIGIT]; // see RQ21
   assign code_delay_on = is_code(xfer, CODE_DELAY_ON); // see RQ6
   assign code_split_off = is_code(xfer, CODE_SPLIT_OFF); // see RQ6
   assign code_split_on = is_code(xfer, CODE_SPLIT_ON); // see RQ6
   assign seq_op = xfer.acc_op != OP_NONE;
   assign ext_word = sign_word(ext_sign_q); // see RQ19
   // a sequencer word in the odd cycle means the transfer went on, so no extension
   assign ext_beat = ext_q && !seq_op; // see RQ18
   assign arm_ext = !ext_q && seq_op && !odd_cycle && double_mode; // see RQ18 see RQ20

   // recirculating line: a write replaces the word at this minor cycle
   always_ff @(posedge clk) begin
      if (line_we) begin
         line_mem[minor_cycle] <= xfer.data; // see RQ5
      end
   end

   // single-word store: loop broken while chained, acts as one extra stage
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         store_q <= WORD_ZERO;
      end else if (store_we) begin
         store_q <= xfer.data; // see RQ4
      end else if (clk_en && delay_chain_q) begin
         store_q <= line_rd; // see RQ1 see RQ3
      end
   end

   // delay-chain trigger: a store write always wins over code 3
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         delay_chain_q <= TRIG_RESET;
      end else if (clk_en) begin
         if (xfer.store_wr) begin
            delay_chain_q <= 1'b0; // see RQ4 see RQ22
         end else if (code_delay_on) begin
            delay_chain_q <= 1'b1; // see RQ6
         end
      end
   end

   // split-word trigger: only codes 4 and 5 move it
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         split_q <= TRIG_RESET;
      end else if (clk_en) begin
         if (code_split_off) begin
            split_q <= 1'b0; // see RQ6
         end else if (code_split_on) begin
            split_q <= 1'b1; // see RQ6 see RQ22
         end
      end
   end

   // operand: the sequencer's word, or the sign word in an extension beat
   always_comb begin
      acc_active = ext_beat || seq_op;
      op_sub = ext_beat ? ext_sub_q : (xfer.acc_op == OP_SUB); // see RQ16
      operand = ext_beat ? ext_word : xfer.data; // see RQ19
      acc_cur = odd_cycle ? acc_odd_q : acc_even_q; // see RQ7
   end

   // carry enters the odd word only straight after an even beat in double-length mode
   always_comb begin
      if (odd_cycle && double_mode && carry_valid_q) begin
         carry_in = carry_q; // see RQ9
      end else begin
         carry_in = op_sub; // see RQ10
      end
   end

   // shift source never alters the accumulator
   always_comb begin
      sum_w = add_word(acc_cur, operand, op_sub, carry_in);
      carry_out = sum_w[WIDTH];
      acc_new = sum_w[WIDTH-1:0];
      shift_d = shift_half(odd_cycle, split_q, acc_even_q, acc_odd_q); // see RQ11
   end

   // less significant half
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         acc_even_q <= WORD_ZERO;
      end else if (clk_en && !odd_cycle) begin
         if (acc_active) begin
            acc_even_q <= acc_new; // see RQ16
         end else if (xfer.acc_load) begin
            acc_even_q <= xfer.data; // see RQ15
         end
      end
   end

   // more significant half; a double shift feeds the shift source back here
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         acc_odd_q <= WORD_ZERO;
      end else if (clk_en && odd_cycle) begin
         if (acc_active) begin
            acc_odd_q <= acc_new; // see RQ16
         end else if (xfer.acc_load) begin
            acc_odd_q <= xfer.data; // see RQ15
         end
      end
   end

   // carry kept from an even beat for the odd beat that follows it only
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         carry_q <= 1'b0;
         carry_valid_q <= 1'b0;
      end else if (clk_en) begin
         // borrow kept in complement form: carry 1 means no borrow
         carry_q <= carry_out; // see RQ9
         carry_valid_q <= acc_active && !odd_cycle;
      end
   end

   // sign extension of a single-length operand ending on an even cycle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ext_q <= 1'b0;
         ext_sub_q <= 1'b0;
         ext_sign_q <= 1'b0;
      end else if (clk_en) begin
         if (arm_ext) begin
            ext_q <= 1'b1; // see RQ18 see RQ20
            ext_sub_q <= xfer.acc_op == OP_SUB;
            ext_sign_q <= top_digit_in; // see RQ19 see RQ21
         end else begin
            ext_q <= 1'b0;
         end
      end
   end

   // outputs change only on enabled edges, so they hold while frozen
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         line_out <= WORD_ZERO;
      end else if (clk_en) begin
         line_out <= line_rd; // see RQ3
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         store_out <= WORD_ZERO;
      end else if (clk_en) begin
         store_out <= store_rd; // see RQ2
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         acc_out <= WORD_ZERO;
      end else if (clk_en) begin
         acc_out <= acc_cur; // see RQ7
      end
   end

   // shows the state before this edge's update of the same half
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         shift_out <= WORD_ZERO;
      end else if (clk_en) begin
         shift_out <= shift_d; // see RQ11
      end
   end

   // extending marks an armed extension; busy only when no sequencer word replaces it
   assign trig_out = '{delay_chain_trigger: delay_chain_q, split_word_trigger: split_q, extending: ext_q};
   assign busy = ext_beat;
endmodule : double_length_accumulator

/* tb/dla_chk.sv */
// checker on the long accumulator ports
`timescale 1ns/100ps
module dla_chk
   import dla_pkg::*;
#(
   parameter int WIDTH = 32
) (
   input wire logic clk, // clock
   input wire logic arst_n, // reset, active low
   input wire logic clk_en, // cycle enable
   input wire logic [dla_pkg::MC_W-1:0] minor_cycle, // cycle number
   input wire dla_pkg::xfer_t xfer, // beat
   input wire logic [WIDTH-1:0] line_out, // line word
   input wire logic [WIDTH-1:0] store_out, // store word
   input wire dla_pkg::trig_state_t trig_out, // triggers
   input wire logic busy // extension
);
   import dla_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // a store write in the same beat wins over code 3
   wire code_ok = clk_en && xfer.ctrl_wr && !xfer.store_wr;
   AST_DELAY_ON: assert property (code_ok && xfer.ctrl_code == CODE_DELAY_ON |=> trig_out.delay_chain_trigger)
      else $error("delay chain not set");
   AST_STORE_OFF: assert property (clk_en && xfer.store_wr |=> !trig_out.delay_chain_trigger)
      else $error("store write left chain on");
   AST_SPLIT_ON: assert property (code_ok && xfer.ctrl_code == CODE_SPLIT_ON |=> trig_out.split_word_trigger)
      else $error("split not set");
   AST_SPLIT_OFF: assert property (code_ok && xfer.ctrl_code == CODE_SPLIT_OFF |=> !trig_out.split_word_trigger)
      else $error("split not cleared");
   AST_DELAY_HOLD: assert property (clk_en && !xfer.store_wr && !xfer.ctrl_wr |=> $stable(trig_out.delay_chain_trigger))
      else $error("chain changed by itself");
   AST_SPLIT_HOLD: assert property (clk_en && !xfer.ctrl_wr |=> $stable(trig_out.split_word_trigger))
      else $error("split changed by itself");
   AST_EXTEND: assert property (clk_en && !busy && !trig_out.split_word_trigger && xfer.acc_op != OP_NONE &&
      !minor_cycle[0] |=> trig_out.extending ##1 !trig_out.extending)
      else $error("even beat not extended once");
   AST_NO_EXTEND: assert property (clk_en && trig_out.split_word_trigger && !xfer.ctrl_wr |=> !busy)
      else $error("extension with split on");
   AST_CHAIN: assert property (clk_en && $past(clk_en) && trig_out.delay_chain_trigger &&
      $past(trig_out.delay_chain_trigger) |=> store_out == $past(line_out))
      else $error("store not one word behind line");
endmodule : dla_chk

bind double_length_accumulator dla_chk #(.WIDTH(WIDTH)) chk (.clk(clk), .arst_n(arst_n), .clk_en(clk_en),
   .minor_cycle(minor_cycle), .xfer(xfer), .line_out(line_out), .store_out(store_out), .trig_out(trig_out),
   .busy(busy));

/* tb/seq_model.sv */
// sequencer model: minor cycle count and beat hand-off
`timescale 1ns/100ps
module seq_model
   import dla_pkg::*;
(
   input wire logic clk, // clock
   input wire logic arst_n, // reset, active low
   input wire dla_pkg::xfer_t beat, // beat from bench
   output logic [dla_pkg::MC_W-1:0] mc_q, // minor cycle
   output dla_pkg::xfer_t xfer // beat to block
);
   import dla_pkg::*;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         mc_q <= '0;
      else
         mc_q <= mc_q + 5'h01;
   end
   // the block decides itself whether an odd beat continues a transfer
   always_comb begin
      xfer = beat;
   end
endmodule : seq_model

/* tb/double_length_accumulator_tb.sv */
// bench: long accumulator driven through sequencer model
`timescale 1ns/100ps
module double_length_accumulator_tb;
   import dla_pkg::*;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic clk_en = 1'b1;
   xfer_t beat = '0;
   xfer_t xfer;
   logic [MC_W-1:0] mc;
   logic [WORD_W-1:0] line_out, store_out, shift_out, acc_out;
   trig_state_t trig_out;
   logic busy;
   int failures = 0;
   int n_checks = 0;
   always #5 clk = ~clk;
   seq_model seq (.clk(clk), .arst_n(arst_n), .beat(beat), .mc_q(mc), .xfer(xfer));
   double_length_accumulator dut (.clk(clk), .arst_n(arst_n), .clk_en(clk_en), .minor_cycle(mc), .xfer(xfer),
      .line_out(line_out), .store_out(store_out), .shift_out(shift_out), .acc_out(acc_out), .trig_out(trig_out),
      .busy(busy));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic end_of_test();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_of_test
   // one beat in a cycle of parity p, bus cleared again in the next cycle
   task automatic send(input logic p, input logic st, input logic ln, input acc_op_t ao, input logic ld,
      input logic [4:0] cd, input logic [31:0] d);
      @(negedge clk);
      if (mc[0] == p) @(negedge clk);
      @(posedge clk) beat <= '{st, ln, ao, ld, cd != 5'h00, cd, d};
      @(posedge clk) beat <= '0;
   endtask : send
   // double-length transfer: even word then odd word in adjacent cycles
   task automatic dbl(input acc_op_t ao, input logic [31:0] de, input logic [31:0] dd);
      @(negedge clk);
      if (mc[0] == 1'b0) @(negedge clk);
      @(posedge clk) beat <= '{1'b0, 1'b0, ao, 1'b0, 1'b0, 5'h00, de};
      @(posedge clk) beat <= '{1'b0, 1'b0, ao, 1'b0, 1'b0, 5'h00, dd};
      @(negedge clk);
      check({31'h0, busy}, 32'h0);
      @(posedge clk) beat <= '0;
   endtask : dbl
   task automatic arith(input acc_op_t ao, input logic [31:0] e0, input logic [31:0] o0, input logic [31:0] d);
      send(1'b0, 1'b0, 1'b0, OP_NONE, 1'b1, 5'h00, e0);
      send(1'b1, 1'b0, 1'b0, OP_NONE, 1'b1, 5'h00, o0);
      send(1'b0, 1'b0, 1'b0, ao, 1'b0, 5'h00, d);
   endtask : arith
   // outputs show the word of the previous cycle's parity
   task automatic acc(input logic [31:0] e, input logic [31:0] o, input logic sp);
      repeat (2) @(negedge clk);
      if (mc[0] == 1'b0) @(negedge clk);
      check(acc_out, e);
      check(shift_out, {sp ? e[31] : o[0], e[31:1]});
      @(negedge clk);
      check(acc_out, o);
      check(shift_out, {o[31], o[31:1]});
   endtask : acc
   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      end_of_test();
   end
   initial begin
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      arith(OP_ADD, 32'hffffffff, 32'h0, 32'h1);
      @(negedge clk);
      check({31'h0, busy}, 32'h1);
      acc(32'h0, 32'h1, 1'b0);
      arith(OP_SUB, 32'h0, 32'h0, 32'h1);
      acc(32'hffffffff, 32'hffffffff, 1'b0);
      arith(OP_ADD, 32'h0, 32'h0, 32'h80000000);
      acc(32'h80000000, 32'hffffffff, 1'b0);
      send(1'b0, 1'b0, 1'b0, OP_NONE, 1'b1, 5'h00, 32'hffffffff);
      send(1'b1, 1'b0, 1'b0, OP_NONE, 1'b1, 5'h00, 32'h0);
      dbl(OP_ADD, 32'h1, 32'h2);
      acc(32'h0, 32'h3, 1'b0);
      send(1'b0, 1'b0, 1'b0, OP_NONE, 1'b1, 5'h00, 32'h0);
      send(1'b1, 1'b0, 1'b0, OP_NONE, 1'b1, 5'h00, 32'h5);
      dbl(OP_SUB, 32'h1, 32'h1);
      acc(32'hffffffff, 32'h3, 1'b0);
      send(1'b0, 1'b0, 1'b0, OP_NONE, 1'b0, CODE_SPLIT_ON, 32'h0);
      arith(OP_ADD, 32'hffffffff, 32'h0, 32'h1);
      send(1'b1, 1'b0, 1'b0, OP_SUB, 1'b0, 5'h00, 32'h1);
      acc(32'h0, 32'hffffffff, 1'b1);
      check(32'(trig_out), 32'h2);
      send(1'b0, 1'b0, 1'b0, OP_NONE, 1'b0, CODE_SPLIT_OFF, 32'h0);
      // tag every line word with its own position
      repeat (32) @(posedge clk) beat <= '{1'b0, 1'b1, OP_NONE, 1'b0, 1'b0, 5'h00, {16'h00a5, 11'h000, mc + 5'h01}};
      @(posedge clk) beat <= '0;
      send(1'b0, 1'b0, 1'b0, OP_NONE, 1'b0, CODE_DELAY_ON, 32'h0);
      repeat (2) @(negedge clk);
      repeat (3) begin
         @(negedge clk);
         check(line_out, {16'h00a5, 11'h000, mc - 5'h01});
         check(store_out, {16'h00a5, 11'h000, mc - 5'h02});
      end
      send(1'b0, 1'b1, 1'b0, OP_NONE, 1'b0, CODE_DELAY_ON, 32'h5a5a0001);
      @(negedge clk);
      check(32'(trig_out), 32'h0);
      repeat (3) @(negedge clk);
      check(store_out, 32'h5a5a0001);
      end_of_test();
   end
endmodule : double_length_accumulator_tb
